// ### dv/etds_board.sv
// Board and platform model facing the sideband block
`timescale 1ns/100ps
module etds_board (
  // Bench side
  input  wire clock,
  input  wire rst,
  input  wire extHot,
  input  wire tckDrive,
  input  wire tapResetN,
  // Device side
  input  wire processorHotNOe,
  output wire processorHotNIn,
  output reg  suppliesStable,
  output wire tck,
  output wire trstN
);
  // Wired-and of both open-drain pullers
  assign processorHotNIn = !(extHot || processorHotNOe);
  assign tck = tckDrive && !rst;
  assign trstN = !rst && tapResetN;
  always @(posedge clock or posedge rst) begin
    if (rst)
      suppliesStable <= 1'b0;
    else
      suppliesStable <= 1'b1;
  end
endmodule

// ### dv/etds_sideband_bench.sv
// Self-checking bench for the sideband block
`timescale 1ns/100ps
module etds_sideband_bench;
  reg clock = 1'b0, rst = 1'b1, warmReset = 1'b0, machineCheckError = 1'b0, internalError = 1'b0;
  reg maxSafeTempReached = 1'b0, thermalControlEnable = 1'b0, extHot = 1'b0, debugRequestN = 1'b1;
  reg debugReadyCore = 1'b0, probeResetReq = 1'b0, tms = 1'b1, tdi = 1'b1;
  reg tckDrive = 1'b0, tapResetN = 1'b1;
  reg [7:0] junctionTemp = 8'h19, breakStatus = 8'h00;
  wire suppliesStable, fatalErrorN, processorHotNIn, processorHotNOut, processorHotNOe, tck, trstN;
  wire overheatShutdownN, thermalControlCircuit, executionHalt, coreRunEnable, debugReadyN;
  wire debugRequested, probeSystemResetN, tdoOut, tdoOe;
  wire [7:0] breakMonitorN;
  integer numErrors = 0, nCompared = 0;
  etds_sideband etds_sideband_i (.*);
  etds_board etds_board_i (.*);
  always #5 clock = ~clock;
  task chk(input logic [7:0] got, input logic [7:0] exp); begin
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  end endtask
  task final_report; begin
    if (numErrors == 0 && nCompared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end endtask
  task t_debug(input logic v); begin
    @(posedge clock) debugRequestN <= v;
    debugReadyCore <= v;
    probeResetReq <= v;
    breakStatus <= {4{v, 1'b0}};
    repeat (2) @(posedge clock);
    #1 chk({debugRequested, debugReadyN, probeSystemResetN}, {3{~v}});
    chk(breakMonitorN, ~{4{v, 1'b0}});
    chk(coreRunEnable, 1'b1);
  end endtask
  task t_tap(input logic b); begin
    @(posedge clock) tdi <= b;
    tms <= 1'b0;
    tckDrive <= 1'b1;
    repeat (2) @(posedge clock);
    tckDrive <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk({tdoOe, tdoOut}, {~b, 1'b0});
  end endtask
  task t_trst; begin
    @(posedge clock) tapResetN <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk(tdoOe, 1'b0);
    @(posedge clock) tapResetN <= 1'b1;
  end endtask
  task t_mce; integer i, n; begin
    n = 0;
    @(posedge clock) machineCheckError <= 1'b1;
    @(posedge clock) machineCheckError <= 1'b0;
    for (i = 0; i < 20; i++) begin
      #1 n += !fatalErrorN;
      @(posedge clock);
    end
    chk(n[7:0], 8'h10);
  end endtask
  task t_internal_error; begin
    @(posedge clock) internalError <= 1'b1;
    @(posedge clock) internalError <= 1'b0;
    repeat (40) @(posedge clock);
    chk(fatalErrorN, 1'b0);
    warmReset <= 1'b1;
    @(posedge clock) warmReset <= 1'b0;
    @(posedge clock) #1 chk(fatalErrorN, 1'b1);
  end endtask
  task t_therm; begin
    @(posedge clock) maxSafeTempReached <= 1'b1;
    thermalControlEnable <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk({processorHotNIn, thermalControlCircuit}, 2'b01);
    @(posedge clock) maxSafeTempReached <= 1'b0;
    extHot <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk({processorHotNOe, thermalControlCircuit}, 2'b01);
    @(posedge clock) extHot <= 1'b0;
    junctionTemp <= 8'h82;
    repeat (2) @(posedge clock);
    #1 chk(overheatShutdownN, 1'b1);
    @(posedge clock) junctionTemp <= 8'h83;
    repeat (2) @(posedge clock);
    #1 chk({overheatShutdownN, executionHalt, coreRunEnable, processorHotNOut}, 4'b0100);
  end endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_debug(1'b1);
    t_debug(1'b0);
    t_mce;
    t_mce;
    t_internal_error;
    t_tap(1'b0);
    t_trst;
    t_tap(1'b1);
    // Trip is sticky, so it runs last
    t_therm;
    final_report;
  end
endmodule
bind etds_sideband etds_sideband_properties #(.BRK_W(BRK_W)) etds_sideband_properties_i (.*);

// ### dv/etds_sideband_properties.sv
// Port assertions for the sideband block
`timescale 1ns/100ps
module etds_sideband_properties #(parameter BRK_W = 8) (
  // Clock and inputs
  input wire             clock,
  input wire             rst,
  input wire             machineCheckError,
  input wire             internalError,
  input wire [7:0]       junctionTemp,
  input wire             maxSafeTempReached,
  input wire [BRK_W-1:0] breakStatus,
  // Outputs, plus the processorHotNIn input
  input wire             fatalErrorN,
  input wire             processorHotNIn,
  input wire             processorHotNOe,
  input wire             overheatShutdownN,
  input wire             thermalControlCircuit,
  input wire             executionHalt,
  input wire [BRK_W-1:0] breakMonitorN
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_mce_start: assert property (machineCheckError && fatalErrorN |=> !fatalErrorN)
    else $error("no fatal error");
  // Falls caused by an internal error excluded: held errors never end the pulse
  a_mce_width: assert property ($fell(fatalErrorN) && !$past(internalError)
    |-> !fatalErrorN[*8] ##1 !fatalErrorN[*8] ##1 fatalErrorN)
    else $error("pulse width");
  a_internal_error_held: assert property (internalError |=> !fatalErrorN)
    else $error("held error");
  a_hot_drive: assert property (1 |=> processorHotNOe == $past(maxSafeTempReached))
    else $error("hot drive");
  a_hot_ext: assert property (!processorHotNIn && !processorHotNOe |=> thermalControlCircuit)
    else $error("external hot");
  a_trip_set: assert property (junctionTemp > 8'h82 |=> !overheatShutdownN)
    else $error("trip");
  a_trip_stay: assert property (!overheatShutdownN |=> !overheatShutdownN && executionHalt)
    else $error("trip sticky");
  a_brk_mon: assert property (1 |=> breakMonitorN == ~$past(breakStatus))
    else $error("break lines");
endmodule

// ### src/etds_map.vh
// Constants for the error, thermal and debug sideband block
`ifndef ETDS_MAP_VH
`define ETDS_MAP_VH
`define ETDS_MCE_PULSE_CYCLES 16
`define ETDS_MCE_CNT_W        5
`define ETDS_TRIP_DEG_C       130
`define ETDS_TEMP_W           8
`define ETDS_BRK_W            8
`endif

// ### src/etds_sideband.v
// Error, thermal, debug and test sideband logic of the processor
`timescale 1ns/100ps
`include "etds_map.vh"

// Operation
// - Machine check error holds fatalErrorN low exactly 16 clock cycles.
// - Internal error holds fatalErrorN low until warm or cold reset.
// - Processor-hot output goes active when sensor reaches max safe temperature.
// - External processor-hot drive activates the thermal control circuit too.
// - Above trip temperature, halt execution and drive overheatShutdownN low.
// - Test reset low at power-on; test logic resets whenever it is asserted.
// - Device drives debugReadyN to show readiness for debug operation.
// - Test data shifts in on tdi and out on open-drain tdo.
// - probeSystemResetN lets an in-target probe drive system reset.
module etds_sideband #(
  parameter MCE_CYCLES = `ETDS_MCE_PULSE_CYCLES,
  parameter TRIP_TEMP  = `ETDS_TRIP_DEG_C,
  parameter BRK_W      = `ETDS_BRK_W
) (
  // Clock and reset
  input  wire                    clock,
  input  wire                    rst,
  input  wire                    warmReset,
  // Core events
  input  wire                    machineCheckError,
  input  wire                    internalError,
  input  wire [`ETDS_TEMP_W-1:0] junctionTemp,
  input  wire                    maxSafeTempReached,
  input  wire                    thermalControlEnable,
  input  wire                    suppliesStable,
  // Error and thermal pins
  output reg                     fatalErrorN,
  input  wire                    processorHotNIn,
  output reg                     processorHotNOut,
  output reg                     processorHotNOe,
  output reg                     overheatShutdownN,
  output reg                     thermalControlCircuit,
  output reg                     executionHalt,
  output reg                     coreRunEnable,
  // Debug pins
  input  wire                    debugRequestN,
  input  wire                    debugReadyCore,
  output reg                     debugReadyN,
  output reg                     debugRequested,
  input  wire [BRK_W-1:0]        breakStatus,
  output reg  [BRK_W-1:0]        breakMonitorN,
  input  wire                    probeResetReq,
  output reg                     probeSystemResetN,
  // Test access port
  input  wire                    tck,
  input  wire                    tms,
  input  wire                    tdi,
  input  wire                    trstN,
  output reg                     tdoOut,
  output reg                     tdoOe
);

  // Cut to the counter and sensor widths on purpose
  localparam [`ETDS_MCE_CNT_W-1:0] MCE_LOAD = MCE_CYCLES[`ETDS_MCE_CNT_W-1:0];
  localparam [`ETDS_TEMP_W-1:0]    TRIP_T   = TRIP_TEMP[`ETDS_TEMP_W-1:0];
  localparam ST_IDLE  = 2'b00;
  localparam ST_PULSE = 2'b01;
  localparam ST_HELD  = 2'b10;

  ////////////////////////////////////////////////////////////////
  // Fatal error sequencing
  reg  [1:0]                errState;
  reg  [1:0]                next_errState;
  reg  [`ETDS_MCE_CNT_W-1:0] errCnt;
  reg  [`ETDS_MCE_CNT_W-1:0] next_errCnt;

  // Counter loads the pulse length and counts down to one;
  // the step from one releases the pin, so the low time is
  // exactly the load value with no extra idle cycle.
  // Limitation: MCE_CYCLES must fit the counter width.
  always @* begin
    next_errState = errState;
    next_errCnt   = errCnt;
    case (errState)
      ST_IDLE: begin
        if (internalError) begin
          next_errState = ST_HELD;
        end else if (machineCheckError) begin
          next_errState = ST_PULSE;
          next_errCnt   = MCE_LOAD;
        end
      end
      ST_PULSE: begin
        // Internal error during a pulse escalates to held
        if (internalError) begin
          next_errState = ST_HELD;
        end else if (errCnt == {{(`ETDS_MCE_CNT_W-1){1'b0}}, 1'b1}) begin
          next_errState = ST_IDLE;
          next_errCnt   = {`ETDS_MCE_CNT_W{1'b0}};
        end else begin
          next_errCnt = errCnt - {{(`ETDS_MCE_CNT_W-1){1'b0}}, 1'b1};
        end
      end
      ST_HELD: begin
        next_errState = ST_HELD;
      end
      default: begin
        next_errState = ST_IDLE;
      end
    endcase
    if (warmReset) begin
      next_errState = ST_IDLE;
      next_errCnt   = {`ETDS_MCE_CNT_W{1'b0}};
    end
  end

  // Pin is registered from the next state, so it falls
  // on the very edge that takes the error event
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      errState    <= ST_IDLE;
      errCnt      <= {`ETDS_MCE_CNT_W{1'b0}};
      fatalErrorN <= 1'b1;
    end else begin
      errState    <= next_errState;
      errCnt      <= next_errCnt;
      fatalErrorN <= (next_errState == ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Thermal protection
  // Own drive is ignored so the open-drain line does not latch itself on
  wire extHot  = ~processorHotNIn & ~processorHotNOe;
  // Strict compare: the trip value itself does not halt
  wire tripHot = (junctionTemp > TRIP_T);

  // Pin data is always low; only the enable moves,
  // which keeps the shared line a true open drain

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      processorHotNOut      <= 1'b0;
      processorHotNOe       <= 1'b0;
      thermalControlCircuit <= 1'b0;
      overheatShutdownN     <= 1'b1;
      executionHalt         <= 1'b0;
      coreRunEnable         <= 1'b0;
    end else begin
      processorHotNOut      <= 1'b0;
      processorHotNOe       <= maxSafeTempReached;
      thermalControlCircuit <= thermalControlEnable & maxSafeTempReached | extHot;
      // Trip is sticky: only cold reset (rst) restarts execution; warmReset does not
      if (tripHot) begin
        overheatShutdownN <= 1'b0;
        executionHalt     <= 1'b1;
      end
      coreRunEnable <= suppliesStable & ~executionHalt & ~tripHot;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Debug sideband
  // Plain registered inversions; no handshake state is kept,
  // so each pin follows its source one cycle late
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      debugRequested    <= 1'b0;
      debugReadyN       <= 1'b1;
      breakMonitorN     <= {BRK_W{1'b1}};
      probeSystemResetN <= 1'b1;
    end else begin
      debugRequested    <= ~debugRequestN;
      debugReadyN       <= ~debugReadyCore;
      breakMonitorN     <= ~breakStatus;
      probeSystemResetN <= ~probeResetReq;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Test access port: bypass path, sampled as synchronous inputs
  reg tckLast;
  reg bypassBit;
  reg shiftActive;

  // Test clock edges seen as changes between two samples;
  // the test clock must run well below the bus clock
  wire tckRise = tck & ~tckLast;
  wire tckFall = ~tck & tckLast;

  // trstN acts as a synchronous clear of the test logic only
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tckLast     <= 1'b0;
      bypassBit   <= 1'b0;
      shiftActive <= 1'b0;
      tdoOut      <= 1'b0;
      tdoOe       <= 1'b0;
    end else if (!trstN) begin
      tckLast     <= 1'b0;
      bypassBit   <= 1'b0;
      shiftActive <= 1'b0;
      tdoOut      <= 1'b0;
      tdoOe       <= 1'b0;
    end else begin
      tckLast <= tck;
      if (tckRise) begin
        bypassBit   <= tdi;
        shiftActive <= ~tms;
      end
      // Output changes on the falling edge, half a period after capture
      if (tckFall) begin
        // Open drain: enable only when pulling low
        tdoOut <= 1'b0;
        tdoOe  <= shiftActive & ~bypassBit;
      end
    end
  end

endmodule
